// File: inc/hps_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
`define HPS_CLK_PERIOD_NS   50
`define HPS_ADDR_W          7
`define HPS_DATA_W          16
`define HPS_REG_RESET       16'h0000
`define HPS_OFF_PWR1        7'h01
`define HPS_OFF_LVOL        7'h1c
`define HPS_OFF_RVOL        7'h1d
`define HPS_OFF_SEQ_ENA     7'h46
`define HPS_OFF_SEQ_START   7'h47
`define HPS_OFF_PUMP        7'h4c
`define HPS_OFF_SERVO       7'h54
`define HPS_OFF_SERVO_STAT  7'h58
`define HPS_OFF_POP         7'h60
`define HPS_BIT_OSCILLATOR_ENABLE     3
`define HPS_BIT_HP_ENA_R    8
`define HPS_BIT_HP_ENA_L    9
`define HPS_BIT_SEQ_ENA     8
`define HPS_BIT_SEQ_LAUNCH  8
`define HPS_BIT_PUMP_ENA    15
`define HPS_BIT_R_INTER     1
`define HPS_BIT_R_OUTP      2
`define HPS_BIT_SERVO_EN0   0
`define HPS_BIT_SERVO_TRIG0 4
`define HPS_BIT_STAT_CAL0   8
`define HPS_VOL_MSB         5
`define HPS_PUMP_VOL_LIMIT  6'h2d
`define HPS_PUMP_DIV        8
`define HPS_CAL_TIME_US     25000
`define HPS_CAL_CYC         (`HPS_CAL_TIME_US * 1000 / `HPS_CLK_PERIOD_NS)
`define HPS_STEP_TIME_US    50
`define HPS_STEP_CYC        (`HPS_STEP_TIME_US * 1000 / `HPS_CLK_PERIOD_NS)
`define HPS_DLY_UNIT_NS     63477
`define HPS_DLY_UNIT_CYC    ((`HPS_DLY_UNIT_NS + `HPS_CLK_PERIOD_NS - 1) / `HPS_CLK_PERIOD_NS)
`define HPS_SEQ_DEPTH       16
`endif

// File: inc/hps_pkg.sv
// Types of the start-up sequencer: script entry and sequencer state
package hps_pkg;
  typedef struct packed {
    logic [6:0] addr;
    logic [3:0] width;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] delay;
    logic       end_of_sequence_flag;
  } hps_entry_t;

  typedef enum logic [1:0] {
    HPS_IDLE,
    HPS_WRITE,
    HPS_WAIT
  } hps_seq_state_t;
endpackage

// File: inc/hps_servo_if.sv
// Control and status between the sequencer core and one servo channel
`timescale 1ns/1ps
interface hps_servo_if;
  logic       enable;
  logic       trigger;
  logic       busy;
  logic       done;
  logic [7:0] correction;
  modport ctl (output enable, output trigger, input busy, input done, input correction);
  modport srv (input enable, input trigger, output busy, output done, output correction);
endinterface

// File: core/hps_servo.sv
// One DC offset servo channel with start-up calibration
`timescale 1ns/1ps
`include "hps_regs.svh"
module hps_servo #(
  parameter int CAL_CYC  = `HPS_CAL_CYC,
  parameter int STEP_CYC = `HPS_STEP_CYC
) (
  input  wire logic  ref_clk_i,
  input  wire logic  nrst_i,
  input  wire logic  meas_above_i,
  hps_servo_if.srv   sv
);
  logic        meas_s1;
  logic        meas_s2;
  logic [31:0] cal_cnt;
  logic [31:0] step_cnt;
  wire         step_due = (step_cnt == 32'(STEP_CYC - 1));
  wire         cal_end  = (cal_cnt == 32'(CAL_CYC - 1));

  always_ff @(posedge ref_clk_i) begin
    meas_s1 <= nrst_i ? meas_above_i : 1'b0;
    meas_s2 <= nrst_i ? meas_s1 : 1'b0;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !sv.enable) begin
      sv.busy  <= 1'b0;
      cal_cnt  <= '0;
      step_cnt <= '0;
      if (!nrst_i) begin
        sv.done       <= 1'b0;
        sv.correction <= 8'h00;
      end
    end else if (sv.trigger && !sv.busy) begin
      sv.busy  <= 1'b1;
      sv.done  <= 1'b0;
      cal_cnt  <= '0;
      step_cnt <= '0;
    end else if (sv.busy) begin
      cal_cnt  <= cal_cnt + 32'd1;
      step_cnt <= step_due ? 32'd0 : step_cnt + 32'd1;
      // Series of one-LSB steps: down while the measurement is above, up while it is not
      if (step_due)
        sv.correction <= meas_s2 ? sv.correction - 8'h01 : sv.correction + 8'h01;
      if (cal_end) begin
        sv.busy <= 1'b0;
        sv.done <= 1'b1;
      end
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_servo_start: assert property (sv.enable && sv.trigger && !sv.busy |=> sv.busy)
    else $error("servo trigger did not start calibration");
  a_servo_done_set: assert property (sv.busy && sv.enable && cal_end |=> sv.done && !sv.busy)
    else $error("servo end did not raise done");
  a_servo_hold: assert property (!sv.busy |=> $stable(sv.correction))
    else $error("correction moved while idle");
  a_servo_disabled: assert property (!sv.enable |=> !sv.busy)
    else $error("servo busy while disabled");
  c_servo_done: cover property ($rose(sv.done));
endmodule

// File: core/hps_core.sv
// Headphone start-up sequencing: registers, write sequencer, pump and servo control
`timescale 1ns/1ps
`include "hps_regs.svh"
module hps_core #(
  parameter int CAL_CYC      = `HPS_CAL_CYC,
  parameter int STEP_CYC     = `HPS_STEP_CYC,
  parameter int DLY_UNIT_CYC = `HPS_DLY_UNIT_CYC,
  parameter int SEQ_DEPTH    = `HPS_SEQ_DEPTH
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [6:0]              reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  output logic [15:0]                  reg_rdata_o,
  input  wire logic                    seq_load_i,
  input  wire logic [3:0]              seq_load_idx_i,
  input  wire hps_pkg::hps_entry_t     seq_load_entry_i,
  output logic                         seq_busy_o,
  input  wire logic [1:0]              meas_above_i,
  output logic [15:0]                  servo_correction_o,
  output logic [1:0]                   servo_enable_o,
  output logic                         oscillator_enable_o,
  output logic [1:0]                   hp_input_stage_enable_o,
  output logic                         right_intermediate_stage_enable_o,
  output logic                         right_output_stage_enable_o,
  output logic [7:0]                   pop_stage_o,
  output logic                         pump_run_o,
  output logic                         pump_clk_o,
  output logic                         pump_mode_o
);
  import hps_pkg::*;

  localparam int NREG = 1 << `HPS_ADDR_W;

  logic [15:0]    regs [0:NREG-1];
  hps_entry_t     seq_mem [0:SEQ_DEPTH-1];
  hps_seq_state_t state;
  logic [3:0]     seq_idx;
  logic [31:0]    wait_cnt;
  logic [7:0]     div_cnt;
  logic           vol_wr_q;

  // Sequencer field write, shaped into a mask and a value
  hps_entry_t  cur;
  wire         seq_wr     = (state == HPS_WRITE);
  wire  [15:0] seq_mask   = ((16'h0001 << cur.width) - 16'h0001) << cur.start;
  wire  [15:0] seq_val    = ({8'h00, cur.data} << cur.start) & seq_mask;
  wire  [31:0] seq_delay  = 32'(DLY_UNIT_CYC) << cur.delay;
  wire         host_servo = reg_wr_i && (reg_addr_i == `HPS_OFF_SERVO);
  wire         seq_servo  = seq_wr && (cur.addr == `HPS_OFF_SERVO);
  wire         launch     = reg_wr_i && (reg_addr_i == `HPS_OFF_SEQ_START)
                            && reg_wdata_i[`HPS_BIT_SEQ_LAUNCH]
                            && regs[`HPS_OFF_SEQ_ENA][`HPS_BIT_SEQ_ENA];
  wire         vol_wr     = (reg_wr_i && (reg_addr_i == `HPS_OFF_LVOL
                                          || reg_addr_i == `HPS_OFF_RVOL))
                            || (seq_wr && (cur.addr == `HPS_OFF_LVOL
                                           || cur.addr == `HPS_OFF_RVOL));
  assign cur = seq_mem[seq_idx];

  // Register file; a host write lands after a sequencer write to the same word
  genvar gr;
  generate
    for (gr = 0; gr < NREG; gr++) begin : g_reg
      wire hit_seq  = seq_wr && (cur.addr == 7'(gr));
      wire hit_host = reg_wr_i && (reg_addr_i == 7'(gr));
      always_ff @(posedge ref_clk_i) begin
        if (!nrst_i)
          regs[gr] <= `HPS_REG_RESET;
        else if (hit_host)
          regs[gr] <= reg_wdata_i;
        else if (hit_seq)
          regs[gr] <= (regs[gr] & ~seq_mask) | seq_val;
      end
    end
  endgenerate

  // Entries are only loaded while the sequencer is idle, so a run sees a stable script
  always_ff @(posedge ref_clk_i) begin
    if (seq_load_i && state == HPS_IDLE)
      seq_mem[seq_load_idx_i] <= seq_load_entry_i;
  end

  // Write sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state    <= HPS_IDLE;
      seq_idx  <= 4'h0;
      wait_cnt <= '0;
    end else if (!regs[`HPS_OFF_SEQ_ENA][`HPS_BIT_SEQ_ENA]) begin
      state    <= HPS_IDLE;
    end else begin
      unique case (state)
        HPS_IDLE: begin
          if (launch) begin
            state   <= HPS_WRITE;
            seq_idx <= 4'h0;
          end
        end
        HPS_WRITE: begin
          wait_cnt <= seq_delay;
          if (cur.delay != 4'h0)
            state <= HPS_WAIT;
          else if (cur.end_of_sequence_flag || seq_idx == 4'(SEQ_DEPTH - 1))
            state <= HPS_IDLE;
          else
            seq_idx <= seq_idx + 4'h1;
        end
        HPS_WAIT: begin
          wait_cnt <= wait_cnt - 32'd1;
          if (wait_cnt <= 32'd1) begin
            if (cur.end_of_sequence_flag || seq_idx == 4'(SEQ_DEPTH - 1))
              state <= HPS_IDLE;
            else begin
              state   <= HPS_WRITE;
              seq_idx <= seq_idx + 4'h1;
            end
          end
        end
      endcase
    end
  end
  assign seq_busy_o = (state != HPS_IDLE);

  // Servo channels
  hps_servo_if sv_if [2] ();
  logic [1:0] servo_busy;
  logic [1:0] servo_done;
  logic [1:0] trig_now;
  logic [1:0] trig_q;
  // Trigger lags one cycle so enable and trigger in one write both take effect
  always_ff @(posedge ref_clk_i) begin
    trig_q <= nrst_i ? trig_now : 2'b00;
  end
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_servo
      assign sv_if[gc].enable  = regs[`HPS_OFF_SERVO][`HPS_BIT_SERVO_EN0 + gc];
      assign trig_now[gc]      = (host_servo && reg_wdata_i[`HPS_BIT_SERVO_TRIG0 + gc])
                                 || (seq_servo && seq_val[`HPS_BIT_SERVO_TRIG0 + gc]);
      assign sv_if[gc].trigger = trig_q[gc];
      assign servo_busy[gc]    = sv_if[gc].busy;
      assign servo_done[gc]    = sv_if[gc].done;
      assign servo_correction_o[8*gc +: 8] = sv_if[gc].correction;
      hps_servo #(
        .CAL_CYC  (CAL_CYC),
        .STEP_CYC (STEP_CYC)
      ) u_servo (
        .ref_clk_i    (ref_clk_i),
        .nrst_i       (nrst_i),
        .meas_above_i (meas_above_i[gc]),
        .sv           (sv_if[gc])
      );
    end
  endgenerate
  assign servo_enable_o = {sv_if[1].enable, sv_if[0].enable};

  // Readback: trigger bits show calibration in progress, status word is live
  logic [15:0] rd_servo;
  logic [15:0] rd_stat;
  logic [15:0] next_rdata;
  assign rd_servo   = {regs[`HPS_OFF_SERVO][15:6], servo_busy, 2'b00,
                       regs[`HPS_OFF_SERVO][1:0]};
  assign rd_stat    = {6'h00, servo_done, 6'h00, servo_done};
  assign next_rdata = (reg_addr_i == `HPS_OFF_SERVO)      ? rd_servo :
                      (reg_addr_i == `HPS_OFF_SERVO_STAT) ? rd_stat  :
                      (reg_addr_i == `HPS_OFF_SEQ_START)  ? {15'h0000, seq_busy_o} :
                      regs[reg_addr_i];
  always_ff @(posedge ref_clk_i) begin
    reg_rdata_o <= nrst_i ? next_rdata : 16'h0000;
  end

  // Stage enables straight from their register bits
  assign oscillator_enable_o               = regs[`HPS_OFF_PWR1][`HPS_BIT_OSCILLATOR_ENABLE];
  assign hp_input_stage_enable_o           = {regs[`HPS_OFF_PWR1][`HPS_BIT_HP_ENA_L],
                                              regs[`HPS_OFF_PWR1][`HPS_BIT_HP_ENA_R]};
  assign right_intermediate_stage_enable_o = regs[`HPS_OFF_POP][`HPS_BIT_R_INTER];
  assign right_output_stage_enable_o       = regs[`HPS_OFF_POP][`HPS_BIT_R_OUTP];
  assign pop_stage_o                       = regs[`HPS_OFF_POP][7:0];

  // Charge pump: gated by its bit and the oscillator, clocked by a fixed divider
  wire pump_on = regs[`HPS_OFF_PUMP][`HPS_BIT_PUMP_ENA] && oscillator_enable_o;
  wire div_end = (div_cnt == 8'(`HPS_PUMP_DIV - 1));
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !pump_on) begin
      div_cnt    <= 8'h00;
      pump_clk_o <= 1'b0;
    end else begin
      div_cnt <= div_end ? 8'h00 : div_cnt + 8'h01;
      if (div_end)
        pump_clk_o <= !pump_clk_o;
    end
  end
  assign pump_run_o = pump_on;

  // High-rail mode when either volume is above the limit; no software mode bit
  wire [5:0] lvol = regs[`HPS_OFF_LVOL][`HPS_VOL_MSB:0];
  wire [5:0] rvol = regs[`HPS_OFF_RVOL][`HPS_VOL_MSB:0];
  always_ff @(posedge ref_clk_i) begin
    pump_mode_o <= nrst_i && ((lvol > `HPS_PUMP_VOL_LIMIT) || (rvol > `HPS_PUMP_VOL_LIMIT));
    vol_wr_q    <= nrst_i && vol_wr;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_pump_gate_off: assert property (!regs[`HPS_OFF_PUMP][`HPS_BIT_PUMP_ENA] |-> !pump_run_o)
    else $error("pump running with its enable clear");
  a_pump_clk_idle: assert property (!pump_run_o |=> !pump_clk_o)
    else $error("pump clock toggling while pump off");
  a_pump_mode_cause: assert property ($changed(pump_mode_o) |-> $past(vol_wr_q))
    else $error("pump mode changed without a volume write");
  a_out_stage_wr: assert property (reg_wr_i && reg_addr_i == `HPS_OFF_POP
                                   |=> right_output_stage_enable_o == $past(reg_wdata_i[2]))
    else $error("right output stage does not follow its bit");
  a_seq_launch: assert property (launch && state == HPS_IDLE |=> seq_wr && seq_idx == 4'h0)
    else $error("launch did not start at entry zero");
  a_seq_order: assert property (seq_wr && cur.delay == 4'h0 && !cur.end_of_sequence_flag && seq_idx != 4'hf
                                && regs[`HPS_OFF_SEQ_ENA][`HPS_BIT_SEQ_ENA]
                                |=> seq_wr && seq_idx == $past(seq_idx) + 4'h1)
    else $error("sequencer skipped an entry");
  a_seq_stop: assert property (seq_wr && cur.end_of_sequence_flag && cur.delay == 4'h0 |=> state == HPS_IDLE)
    else $error("sequencer ran past the end flag");
  a_seq_wait: assert property (seq_wr && cur.delay != 4'h0
                               && regs[`HPS_OFF_SEQ_ENA][`HPS_BIT_SEQ_ENA]
                               |=> state == HPS_WAIT && wait_cnt == $past(seq_delay))
    else $error("entry delay not applied");
  c_launch:   cover property (launch);
  c_seq_end:  cover property (seq_wr && cur.end_of_sequence_flag);
  c_pump_on:  cover property ($rose(pump_run_o));
endmodule

// File: bench/hps_core_tb.sv
// Self-checking testbench for the headphone start-up sequencing core
`timescale 1ns/1ps
`include "hps_regs.svh"
module hps_core_tb;
  import hps_pkg::*;
  logic              ref_clk_i;
  logic              nrst_i;
  logic              reg_wr_i;
  logic [6:0]        reg_addr_i;
  logic [15:0]       reg_wdata_i;
  logic [15:0]       reg_rdata_o;
  logic              seq_load_i;
  logic [3:0]        seq_load_idx_i;
  hps_entry_t        seq_load_entry_i;
  logic              seq_busy_o;
  logic [1:0]        meas_above_i;
  logic [15:0]       servo_correction_o;
  logic [1:0]        servo_enable_o;
  logic              oscillator_enable_o;
  logic [1:0]        hp_input_stage_enable_o;
  logic              right_intermediate_stage_enable_o;
  logic              right_output_stage_enable_o;
  logic [7:0]        pop_stage_o;
  logic              pump_run_o;
  logic              pump_clk_o;
  logic              pump_mode_o;
  int                error_cnt;
  int                n_tests;

  // Short counts keep the run small
  hps_core #(.CAL_CYC(40), .STEP_CYC(4), .DLY_UNIT_CYC(2), .SEQ_DEPTH(16)) u_hps_core (
    .ref_clk_i                         (ref_clk_i),
    .nrst_i                            (nrst_i),
    .reg_wr_i                          (reg_wr_i),
    .reg_addr_i                        (reg_addr_i),
    .reg_wdata_i                       (reg_wdata_i),
    .reg_rdata_o                       (reg_rdata_o),
    .seq_load_i                        (seq_load_i),
    .seq_load_idx_i                    (seq_load_idx_i),
    .seq_load_entry_i                  (seq_load_entry_i),
    .seq_busy_o                        (seq_busy_o),
    .meas_above_i                      (meas_above_i),
    .servo_correction_o                (servo_correction_o),
    .servo_enable_o                    (servo_enable_o),
    .oscillator_enable_o               (oscillator_enable_o),
    .hp_input_stage_enable_o           (hp_input_stage_enable_o),
    .right_intermediate_stage_enable_o (right_intermediate_stage_enable_o),
    .right_output_stage_enable_o       (right_output_stage_enable_o),
    .pop_stage_o                       (pop_stage_o),
    .pump_run_o                        (pump_run_o),
    .pump_clk_o                        (pump_clk_o),
    .pump_mode_o                       (pump_mode_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // All drives land one ns after the rising edge
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    tick();
    chk(reg_rdata_o, exp, "read");
  endtask

  task automatic load(input logic [3:0] i, input hps_entry_t e);
    seq_load_i       = 1'b1;
    seq_load_idx_i   = i;
    seq_load_entry_i = e;
    tick();
    seq_load_i = 1'b0;
    tick();
  endtask

  // Poll a register until it shows the value, bounded
  task automatic poll(input logic [6:0] a, input logic [15:0] exp);
    int k;
    reg_addr_i = a;
    for (k = 0; k < 2000 && reg_rdata_o !== exp; k++) tick();
    if (k == 2000) begin
      $display("[ERR] t=%0t poll timeout", $time);
      error_cnt++;
      conclude();
    end
  endtask

  initial begin
    logic [15:0] held;
    int          tg;
    logic        prev;
    error_cnt = 0;
    n_tests = 0;
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 7'h00;
    reg_wdata_i = 16'h0000;
    seq_load_i = 1'b0;
    seq_load_idx_i = 4'h0;
    seq_load_entry_i = '0;
    meas_above_i = 2'b00;
    repeat (6) tick();
    nrst_i = 1'b1;
    tick();
    rd(7'h60, 16'h0000);
    rd(7'h4c, 16'h0000);
    rd(7'h54, 16'h0000);
    chk({15'h0, pump_run_o}, 16'h0000, "pump idle");
    $display("test reset done");

    wr(7'h60, 16'h0004);
    chk({14'h0, right_intermediate_stage_enable_o, right_output_stage_enable_o}, 16'h0001,
        "outp");
    wr(7'h01, 16'h0200);
    chk({14'h0, hp_input_stage_enable_o}, 16'h0002, "left input stage");
    repeat (400) tick();
    wr(7'h60, 16'h0002);
    chk({14'h0, right_intermediate_stage_enable_o, right_output_stage_enable_o}, 16'h0002,
        "inter");
    $display("test pop stages done");

    wr(7'h4c, 16'h8000);
    chk({15'h0, pump_run_o}, 16'h0000, "pump no osc");
    wr(7'h01, 16'h000b);
    chk({15'h0, pump_run_o}, 16'h0001, "pump run");
    tg = 0;
    prev = pump_clk_o;
    repeat (64) begin
      tick();
      if (pump_clk_o !== prev) tg++;
      prev = pump_clk_o;
    end
    chk(16'(tg), 16'd8, "pump clk toggles");
    wr(7'h4c, 16'h0000);
    tick();
    chk({14'h0, pump_run_o, pump_clk_o}, 16'h0000, "pump off");
    $display("test pump done");

    wr(7'h1c, 16'h002e);
    chk({15'h0, pump_mode_o}, 16'h0001, "mode left");
    wr(7'h1c, 16'h002d);
    chk({15'h0, pump_mode_o}, 16'h0000, "mode at limit");
    wr(7'h1d, 16'h003f);
    chk({15'h0, pump_mode_o}, 16'h0001, "mode right");
    wr(7'h1d, 16'h0000);
    $display("test pump mode done");

    meas_above_i = 2'b10;
    wr(7'h54, 16'h0003);
    chk({14'h0, servo_enable_o}, 16'h0003, "servo enable");
    wr(7'h54, 16'h0033);
    rd(7'h54, 16'h0033);
    poll(7'h58, 16'h0303);
    rd(7'h54, 16'h0003);
    chk(servo_correction_o, 16'hf60a, "correction steps");
    held = servo_correction_o;
    meas_above_i = 2'b01;
    repeat (20) tick();
    chk(servo_correction_o, held, "correction held");
    $display("test servo done");

    load(4'h0, '{addr: 7'h4c, width: 4'h1, start: 4'hf, data: 8'h01, delay: 4'h0, end_of_sequence_flag: 1'b0});
    load(4'h1, '{addr: 7'h60, width: 4'h6, start: 4'h0, data: 8'h22, delay: 4'h1, end_of_sequence_flag: 1'b0});
    load(4'h2, '{addr: 7'h60, width: 4'h8, start: 4'h0, data: 8'hee, delay: 4'h0, end_of_sequence_flag: 1'b1});
    load(4'h3, '{addr: 7'h1c, width: 4'h6, start: 4'h0, data: 8'h3f, delay: 4'h0, end_of_sequence_flag: 1'b1});
    wr(7'h46, 16'h0100);
    wr(7'h47, 16'h0100);
    chk({15'h0, seq_busy_o}, 16'h0001, "seq busy");
    poll(7'h47, 16'h0000);
    rd(7'h4c, 16'h8000);
    rd(7'h60, 16'h00ee);
    rd(7'h1c, 16'h002d);
    chk({14'h0, pump_run_o, right_output_stage_enable_o}, 16'h0003, "seq outputs");
    $display("test sequencer done");

    wr(7'h54, 16'h0000);
    wr(7'h60, 16'h0000);
    load(4'h0, '{7'h4c, 4'h1, 4'hf, 8'h01, 4'h0, 1'b0});
    load(4'h1, '{7'h03, 4'h2, 4'h4, 8'h03, 4'h0, 1'b0});
    load(4'h2, '{7'h2d, 4'h1, 4'h6, 8'h01, 4'h0, 1'b0});
    load(4'h3, '{7'h2e, 4'h1, 4'h4, 8'h01, 4'h0, 1'b0});
    load(4'h4, '{7'h2f, 4'h1, 4'h8, 8'h00, 4'h0, 1'b0});
    load(4'h5, '{7'h30, 4'h1, 4'h8, 8'h00, 4'h0, 1'b0});
    load(4'h6, '{7'h1c, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0});
    load(4'h7, '{7'h1d, 4'h1, 4'h8, 8'h01, 4'h0, 1'b0});
    load(4'h8, '{7'h01, 4'h2, 4'h8, 8'h03, 4'h0, 1'b0});
    load(4'h9, '{7'h60, 4'h6, 4'h0, 8'h22, 4'h0, 1'b0});
    load(4'ha, '{7'h54, 4'h6, 4'h0, 8'h33, 4'h9, 1'b0});
    load(4'hb, '{7'h60, 4'h8, 4'h0, 8'hee, 4'h0, 1'b1});
    wr(7'h01, 16'h000b);
    wr(7'h02, 16'h60c0);
    wr(7'h16, 16'h0000);
    wr(7'h18, 16'h0100);
    wr(7'h19, 16'h0100);
    wr(7'h46, 16'h0100);
    wr(7'h47, 16'h0100);
    chk({15'h0, seq_busy_o}, 16'h0001, "script busy");
    poll(7'h47, 16'h0000);
    rd(7'h2d, 16'h0040);
    rd(7'h2e, 16'h0010);
    rd(7'h03, 16'h0030);
    rd(7'h18, 16'h0100);
    rd(7'h54, 16'h0003);
    rd(7'h58, 16'h0303);
    chk(servo_correction_o, 16'h0000, "script correction");
    chk({5'h00, hp_input_stage_enable_o, oscillator_enable_o, pop_stage_o}, 16'h07ee,
        "script stages");
    $display("test start-up script done");
    conclude();
  end
endmodule
